/* hw/tcm_pkg.sv */
// constants and carrier types for the module control and thermal monitor block
// assumes a single 100 MHz clock; pins and the serial bus arrive asynchronously
//
// Overview of operation
// - each control is a P/M pair; undriven reads state 1, state 0 is rx/port1/amp on
// - tx/rx select moves RF and IF switches together; antenna select picks waveguide port
// - separate power and receive amp enables for both modules; first only on primary connector
// - trim input held low advances the potentiometer every 100 ms
// - potentiometer has 64 positions and reverses direction at either end
// - detector output is driven only while the transmit amp is enabled, else released
// - with chained modules only the transmit-active module drives the shared detector line
// - temperature reading is served to a serial master in a sensor-style register format
// - outside the safe range the module shuts down and pulls the alert line low
// - critical and general alert flags share one open-drain alert line across modules
// - critical setpoint is serially writable and resets to 127 degrees
// - readings are 8 bits, 1 degree steps, msb set below zero
// - codes are two's complement, linear from -55 to +125 degrees
// - serial address is 7 bits, one of them set by a factory strap
package tcm_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int TRIM_REPEAT_MS = 100;
	localparam int TRIM_REPEAT_CYC = CLK_HZ / 1000 * TRIM_REPEAT_MS;
	localparam int TRIM_DEBOUNCE_US = 20;
	localparam int TRIM_DEBOUNCE_CYC = CLK_HZ / 1_000_000 * TRIM_DEBOUNCE_US;

	// ****************************************
	// potentiometer and temperature
	// ****************************************
	localparam int POT_W = 6;
	localparam logic [5:0] POT_MAX = 6'h3f;
	localparam logic [5:0] POT_MIN = 6'h00;
	localparam logic [5:0] POT_RESET = 6'h20;
	localparam logic [7:0] CRIT_RESET = 8'h7f;
	localparam logic [7:0] LOW_RESET = 8'hc9;
	localparam logic [7:0] TEMP_RESET = 8'h00;

	// ****************************************
	// serial side
	// ****************************************
	localparam logic [6:0] SER_ADDR_DEFAULT = 7'h2a;
	localparam int SER_STRAP_BIT = 0;
	localparam logic [7:0] SP_TEMP = 8'h00;
	localparam logic [7:0] SP_CRIT = 8'h01;
	localparam logic [7:0] SP_LOW = 8'h02;
	localparam logic [7:0] SP_FLAGS = 8'h03;

	// ****************************************
	// control pair lanes
	// ****************************************
	localparam int CTL_N = 6;
	localparam int CI_TXRX = 0;
	localparam int CI_ANT = 1;
	localparam int CI_PA_A = 2;
	localparam int CI_PA_B = 3;
	localparam int CI_RX_A = 4;
	localparam int CI_RX_B = 5;

	// ****************************************
	// host register port
	// ****************************************
	localparam logic [2:0] RA_STATUS = 3'h0;
	localparam logic [2:0] RA_MASK = 3'h1;
	localparam logic [2:0] RA_CONTROL = 3'h2;
	localparam logic [2:0] RA_POT = 3'h3;
	localparam logic [2:0] RA_TEMP = 3'h4;
	localparam logic [2:0] RA_CRIT = 3'h5;
	localparam logic [2:0] RA_LOW = 3'h6;
	localparam int ST_CRIT = 0;
	localparam int ST_LOW = 1;
	localparam int ST_STEP = 2;
	localparam int ST_SERWR = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;

	typedef struct packed {
		logic stb;
		logic [7:0] ptr;
		logic [7:0] data;
	} tcm_swr_t;

	typedef struct packed {
		logic [5:0] state1;
		logic shutdown;
	} tcm_ctl_t;

endpackage : tcm_pkg

/* hw/tcm_serial_slave.sv */
// byte-level two-wire slave for the temperature monitor registers
// assumes scl and sda already pass two flip-flops in the caller's clock
`timescale 1ns/1ps

module tcm_serial_slave
	import tcm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic [6:0] dev_addr,
	input wire logic [7:0] rd_data,
	output logic [7:0] ptr,
	output logic sda_oe_n,
	output tcm_swr_t wr
);

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WR, S_RD, S_RACK} tcm_ph_t;

	typedef struct packed {
		logic scl_p;
		logic sda_p;
		tcm_ph_t ph;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rw;
		logic have_ptr;
		logic [7:0] ptr;
		logic pull;
		tcm_swr_t wr;
	} tcm_ss_t;

	tcm_ss_t q, n;

	always_comb begin
		n = q;
		n.scl_p = scl;
		n.sda_p = sda;
		n.wr.stb = 1'b0;
		// data changes only while scl is low, so our own pull never fakes a start
		if (q.scl_p && scl && q.sda_p && !sda) begin
			n.ph = S_ADDR;
			n.bitc = 4'h0;
			n.have_ptr = 1'b0;
			n.pull = 1'b0;
		end else if (q.scl_p && scl && !q.sda_p && sda) begin
			n.ph = S_IDLE;
			n.pull = 1'b0;
		end else if (!q.scl_p && scl) begin
			unique case (q.ph)
				S_ADDR, S_WR: begin
					n.sh = {q.sh[6:0], sda};
					n.bitc = q.bitc + 4'h1;
				end
				S_RD: n.bitc = q.bitc + 4'h1;
				S_RACK: if (sda) n.ph = S_IDLE;
				S_IDLE, S_ACK: ;
			endcase
		end else if (q.scl_p && !scl) begin
			unique case (q.ph)
				S_ADDR: if (q.bitc == 4'h8) begin
					if (q.sh[7:1] == dev_addr) begin
						n.ph = S_ACK;
						n.rw = q.sh[0];
						n.pull = 1'b1;
					end else begin
						n.ph = S_IDLE;
					end
				end
				S_ACK: begin
					n.bitc = 4'h0;
					if (q.rw) begin
						n.ph = S_RD;
						n.sh = rd_data;
						n.pull = !rd_data[7];
					end else begin
						n.ph = S_WR;
						n.pull = 1'b0;
					end
				end
				S_WR: if (q.bitc == 4'h8) begin
					n.ph = S_ACK;
					n.pull = 1'b1;
					if (!q.have_ptr) begin
						n.ptr = q.sh;
						n.have_ptr = 1'b1;
					end else begin
						n.wr.stb = 1'b1;
						n.wr.ptr = q.ptr;
						n.wr.data = q.sh;
					end
				end
				S_RD: if (q.bitc == 4'h8) begin
					n.ph = S_RACK;
					n.pull = 1'b0;
				end else begin
					n.sh = {q.sh[6:0], 1'b0};
					n.pull = !q.sh[6];
				end
				S_RACK: begin
					n.ph = S_RD;
					n.bitc = 4'h0;
					n.sh = rd_data;
					n.pull = !rd_data[7];
				end
				S_IDLE: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '{scl_p: 1'b1, sda_p: 1'b1, ph: S_IDLE, bitc: 4'h0, sh: 8'h00, rw: 1'b0,
				have_ptr: 1'b0, ptr: SP_TEMP, pull: 1'b0, wr: '0};
		end else begin
			q <= n;
		end
	end

	assign ptr = q.ptr;
	assign sda_oe_n = !q.pull;
	assign wr = q.wr;

endmodule : tcm_serial_slave

/* hw/tcm_top.sv */
// control decode, detector trim, thermal monitor and host registers of the module
// assumes pins are asynchronous to CLK; temperature codes arrive from a converter on CLK
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module tcm_top
	import tcm_pkg::*;
#(
	parameter int REPEAT_CYC = TRIM_REPEAT_CYC,
	parameter bit PRIMARY_CONNECTOR = 1'b1,
	parameter bit DET_FOLLOWS_B = 1'b0
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [CTL_N-1:0] CTL_P,
	input wire logic [CTL_N-1:0] CTL_M,
	input wire logic TRIM_N,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	input wire logic ADDR_STRAP,
	input wire logic [7:0] TEMP_CODE,
	input wire logic TEMP_VALID,
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic RF_SWITCH_TX,
	output logic IF_SWITCH_TX,
	output logic ANT_PORT2,
	output logic PA_A_ON,
	output logic PA_B_ON,
	output logic RX_A_ON,
	output logic RX_B_ON,
	output logic [POT_W-1:0] POT_POSITION,
	output logic POT_UP,
	output logic DET_OE_N,
	output logic SHUTDOWN,
	output logic ALERT_OUT,
	output logic ALERT_OE_N,
	output logic IRQ
);

	localparam int RW = $clog2(REPEAT_CYC + 1);
	localparam int DW = $clog2(TRIM_DEBOUNCE_CYC + 1);
	localparam logic [RW-1:0] REP_LAST = RW'(REPEAT_CYC - 1);
	localparam logic [DW-1:0] DEB_LAST = DW'(TRIM_DEBOUNCE_CYC - 1);

	typedef struct packed {
		logic [CTL_N-1:0] p_s1;
		logic [CTL_N-1:0] p_s2;
		logic [CTL_N-1:0] m_s1;
		logic [CTL_N-1:0] m_s2;
		logic [1:0] trim_s;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] strap_s;
		logic trim_db;
		logic [DW-1:0] deb_cnt;
		logic [RW-1:0] rep_cnt;
		logic [POT_W-1:0] pot;
		logic pot_up;
		logic [7:0] temp;
		logic [7:0] crit;
		logic [7:0] low;
		logic crit_flag;
		logic low_flag;
		logic [3:0] status;
		logic [3:0] mask;
		logic irq;
		logic [7:0] rdata;
		logic rf_tx;
		logic if_tx;
		logic ant2;
		logic pa_a;
		logic pa_b;
		logic rx_a;
		logic rx_b;
		logic det_oe_n;
		logic shutdown;
		logic alert_oe_n;
	} tcm_st_t;

	tcm_st_t q, n;
	logic [CTL_N-1:0] state1;
	logic [7:0] ser_rd;
	logic [7:0] ser_ptr;
	logic ser_oe_n;
	tcm_swr_t ser_wr;
	logic [6:0] dev_addr;
	tcm_ctl_t ctl;

	// ****************************************
	// control pair decode
	// ****************************************
	// only a clear low-high pair reads as 0, so an open pair falls to state 1
	generate
		for (genvar i = 0; i < CTL_N; i++) begin : g_pair
			assign state1[i] = !(!q.p_s2[i] && q.m_s2[i]);
		end
	endgenerate

	assign ctl = '{state1: state1, shutdown: q.shutdown};

	// ****************************************
	// serial slave
	// ****************************************
	always_comb begin
		dev_addr = SER_ADDR_DEFAULT;
		dev_addr[SER_STRAP_BIT] = q.strap_s[1];
	end

	always_comb begin
		unique case (ser_ptr)
			SP_TEMP: ser_rd = q.temp;
			SP_CRIT: ser_rd = q.crit;
			SP_LOW: ser_rd = q.low;
			SP_FLAGS: ser_rd = {6'h00, q.low_flag, q.crit_flag};
			default: ser_rd = 8'h00;
		endcase
	end

	tcm_serial_slave u_serial (
		.clk(CLK),
		.reset_n(RESET_N),
		.scl(q.scl_s[1]),
		.sda(q.sda_s[1]),
		.dev_addr(dev_addr),
		.rd_data(ser_rd),
		.ptr(ser_ptr),
		.sda_oe_n(ser_oe_n),
		.wr(ser_wr)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic step;
		logic [3:0] ev;
		logic [3:0] clr;
		logic hi;
		logic lo;
		step = 1'b0;
		ev = 4'h0;
		clr = 4'h0;
		hi = 1'b0;
		lo = 1'b0;
		n = q;

		// pins pass two flops before anything looks at them
		n.p_s1 = CTL_P;
		n.p_s2 = q.p_s1;
		n.m_s1 = CTL_M;
		n.m_s2 = q.m_s1;
		n.trim_s = {q.trim_s[0], TRIM_N};
		n.scl_s = {q.scl_s[0], SCL};
		n.sda_s = {q.sda_s[0], SDA_IN};
		n.strap_s = {q.strap_s[0], ADDR_STRAP};

		// controls; shutdown forces every amplifier off
		n.rf_tx = ctl.state1[CI_TXRX];
		n.if_tx = ctl.state1[CI_TXRX];
		n.ant2 = ctl.state1[CI_ANT];
		n.pa_a = PRIMARY_CONNECTOR && !ctl.state1[CI_PA_A] && !ctl.shutdown;
		n.rx_a = PRIMARY_CONNECTOR && !ctl.state1[CI_RX_A] && !ctl.shutdown;
		n.pa_b = !ctl.state1[CI_PA_B] && !ctl.shutdown;
		n.rx_b = !ctl.state1[CI_RX_B] && !ctl.shutdown;
		// own transmit amp only, so a chained partner owns the line when it transmits
		n.det_oe_n = DET_FOLLOWS_B ? !n.pa_b : !n.pa_a;

		// trim debounce: a level must hold for the debounce time to count
		if (q.trim_s[1] != q.trim_db) begin
			if (q.deb_cnt == DEB_LAST) begin
				n.trim_db = q.trim_s[1];
				n.deb_cnt = '0;
				n.rep_cnt = '0;
				step = !q.trim_s[1];
			end else begin
				n.deb_cnt = q.deb_cnt + DW'(1);
			end
		end else begin
			n.deb_cnt = '0;
			if (!q.trim_db) begin
				if (q.rep_cnt == REP_LAST) begin
					n.rep_cnt = '0;
					step = 1'b1;
				end else begin
					n.rep_cnt = q.rep_cnt + RW'(1);
				end
			end
		end

		// turn round once an end stop is reached
		if (step) begin
			ev[ST_STEP] = 1'b1;
			if (q.pot_up) begin
				n.pot = q.pot + POT_W'(1);
				if (n.pot == POT_MAX) n.pot_up = 1'b0;
			end else begin
				n.pot = q.pot - POT_W'(1);
				if (n.pot == POT_MIN) n.pot_up = 1'b1;
			end
		end

		// setpoints from the serial master
		if (ser_wr.stb) begin
			ev[ST_SERWR] = 1'b1;
			if (ser_wr.ptr == SP_CRIT) n.crit = ser_wr.data;
			if (ser_wr.ptr == SP_LOW) n.low = ser_wr.data;
		end

		// signed compare, codes are two's complement degrees
		if (TEMP_VALID) begin
			n.temp = TEMP_CODE;
			hi = $signed(TEMP_CODE) >= $signed(n.crit);
			lo = $signed(TEMP_CODE) < $signed(n.low);
			n.crit_flag = hi;
			n.low_flag = lo;
			ev[ST_CRIT] = hi && !q.crit_flag;
			ev[ST_LOW] = lo && !q.low_flag;
		end
		n.shutdown = n.crit_flag || n.low_flag;
		n.alert_oe_n = !(n.crit_flag || n.low_flag);

		// host port
		n.rdata = 8'h00;
		if (REG_WR) begin
			unique case (REG_ADDR)
				RA_STATUS: clr = REG_WDATA[3:0];
				RA_MASK: n.mask = REG_WDATA[3:0];
				RA_CRIT: n.crit = REG_WDATA;
				RA_LOW: n.low = REG_WDATA;
				default: ;
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				RA_STATUS: n.rdata = {4'h0, q.status};
				RA_MASK: n.rdata = {4'h0, q.mask};
				RA_CONTROL: n.rdata = {1'b0, q.shutdown, state1};
				RA_POT: n.rdata = {1'b0, q.pot_up, q.pot};
				RA_TEMP: n.rdata = q.temp;
				RA_CRIT: n.rdata = q.crit;
				RA_LOW: n.rdata = q.low;
				default: n.rdata = 8'h00;
			endcase
		end
		// a new event outranks a clear landing in the same cycle
		n.status = (q.status & ~clr) | ev;
		n.irq = |(n.status & n.mask);
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			q <= '{p_s1: '1, p_s2: '1, m_s1: '0, m_s2: '0, trim_s: 2'h3, scl_s: 2'h3,
				sda_s: 2'h3, strap_s: 2'h0, trim_db: 1'b1, deb_cnt: '0, rep_cnt: '0,
				pot: POT_RESET, pot_up: 1'b1, temp: TEMP_RESET, crit: CRIT_RESET,
				low: LOW_RESET, crit_flag: 1'b0, low_flag: 1'b0, status: STATUS_RESET,
				mask: MASK_RESET, irq: 1'b0, rdata: 8'h00, rf_tx: 1'b1, if_tx: 1'b1,
				ant2: 1'b1, pa_a: 1'b0, pa_b: 1'b0, rx_a: 1'b0, rx_b: 1'b0,
				det_oe_n: 1'b1, shutdown: 1'b0, alert_oe_n: 1'b1};
		end else begin
			q <= n;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// open-drain lines only ever pull low, so their data is a constant zero
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N = ser_oe_n;
	assign REG_RDATA = q.rdata;
	assign RF_SWITCH_TX = q.rf_tx;
	assign IF_SWITCH_TX = q.if_tx;
	assign ANT_PORT2 = q.ant2;
	assign PA_A_ON = q.pa_a;
	assign PA_B_ON = q.pa_b;
	assign RX_A_ON = q.rx_a;
	assign RX_B_ON = q.rx_b;
	assign POT_POSITION = q.pot;
	assign POT_UP = q.pot_up;
	assign DET_OE_N = q.det_oe_n;
	assign SHUTDOWN = q.shutdown;
	assign ALERT_OUT = 1'b0;
	assign ALERT_OE_N = q.alert_oe_n;
	assign IRQ = q.irq;

endmodule : tcm_top

/* sim/tcm_top_monitor.sv */
// concurrent checks on the pins of tcm_top
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps

module tcm_top_monitor
	import tcm_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] TEMP_CODE,
	input wire logic TEMP_VALID,
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic RF_SWITCH_TX,
	input wire logic IF_SWITCH_TX,
	input wire logic PA_A_ON,
	input wire logic PA_B_ON,
	input wire logic RX_A_ON,
	input wire logic RX_B_ON,
	input wire logic [POT_W-1:0] POT_POSITION,
	input wire logic POT_UP,
	input wire logic DET_OE_N,
	input wire logic SHUTDOWN,
	input wire logic ALERT_OE_N,
	input wire logic IRQ
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	a_switch_pair: assert property (RF_SWITCH_TX == IF_SWITCH_TX)
		else $error("switches disagree");
	a_det_drive: assert property (DET_OE_N == !PA_A_ON)
		else $error("detector drive wrong");
	a_shut_amps: assert property (SHUTDOWN |=> !(PA_A_ON || PA_B_ON || RX_A_ON || RX_B_ON))
		else $error("amp on in shutdown");
	a_alert_track: assert property (ALERT_OE_N == !SHUTDOWN)
		else $error("alert and shutdown differ");
	a_hot_code: assert property (TEMP_VALID && TEMP_CODE == 8'h7f |=> SHUTDOWN && !ALERT_OE_N)
		else $error("no shutdown on hot code");
	a_pot_step: assert property ($changed(POT_POSITION) |->
		POT_POSITION == ($past(POT_UP) ? $past(POT_POSITION) + 6'h01 :
		$past(POT_POSITION) - 6'h01))
		else $error("bad pot step");
	a_pot_top: assert property (POT_POSITION == POT_MAX |=> !POT_UP)
		else $error("no turn at top");
	a_pot_bottom: assert property (POT_POSITION == POT_MIN |=> POT_UP)
		else $error("no turn at bottom");
	a_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data outside slot");
	a_rd_unmapped: assert property (REG_RD && REG_ADDR == 3'h7 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_mask_off: assert property (REG_WR && REG_ADDR == RA_MASK && REG_WDATA == 8'h00 |-> ##2 !IRQ)
		else $error("irq with mask clear");
endmodule : tcm_top_monitor

bind tcm_top tcm_top_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N), .TEMP_CODE(TEMP_CODE),
	.TEMP_VALID(TEMP_VALID), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RF_SWITCH_TX(RF_SWITCH_TX),
	.IF_SWITCH_TX(IF_SWITCH_TX), .PA_A_ON(PA_A_ON), .PA_B_ON(PA_B_ON), .RX_A_ON(RX_A_ON),
	.RX_B_ON(RX_B_ON), .POT_POSITION(POT_POSITION), .POT_UP(POT_UP), .DET_OE_N(DET_OE_N),
	.SHUTDOWN(SHUTDOWN), .ALERT_OE_N(ALERT_OE_N), .IRQ(IRQ));

/* sim/tcm_odu_model.sv */
// outdoor unit controller model: control pairs, trim line, serial master
// assumes clk is the block clock and sda_wire is the resolved pulled-up line
`timescale 1ns/1ps

module tcm_odu_model (
	input wire logic clk,
	input wire logic sda_wire,
	output logic [5:0] ctl_p,
	output logic [5:0] ctl_m,
	output logic trim_n,
	output logic scl,
	output logic sda_m
);
	// ****
	// pins undriven, bus released, clock parked high between frames
	// ****
	initial begin
		ctl_p = 6'h3f;
		ctl_m = 6'h3f;
		trim_n = 1'b1;
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// s is the wanted state, u marks lanes left undriven
	task automatic set_lanes(input logic [5:0] s, input logic [5:0] u);
		@(posedge clk);
		ctl_p <= s | u;
		ctl_m <= ~s | u;
	endtask : set_lanes
	// falls stay over 20 us apart except the deliberate glitch
	task automatic trim(input logic v);
		@(posedge clk);
		trim_n <= v;
	endtask : trim
	// one bit in 80 ns; data moves only while scl is low
	task automatic sbit(input logic b, output logic r);
		@(posedge clk);
		sda_m <= b;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (2) @(posedge clk);
		r = sda_wire;
		repeat (2) @(posedge clk);
		scl <= 1'b0;
	endtask : sbit
	task automatic sbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) sbit(d[i], r);
		sbit(1'b1, r);
		ack = !r;
	endtask : sbyte
	// start, or repeated start after an acknowledge; sda rises while scl is low, then falls while scl is high
	task automatic sstart();
		@(posedge clk);
		sda_m <= 1'b1;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_m <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
	endtask : sstart
	task automatic sstop();
		@(posedge clk);
		sda_m <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_m <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : sstop
	// address, pointer and one data byte; an address no slave answers leaves its acks low
	task automatic swrite(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic [2:0] acks);
		sstart();
		sbyte({a, 1'b0}, acks[2]);
		sbyte(p, acks[1]);
		sbyte(d, acks[0]);
		sstop();
	endtask : swrite
	// pointer write, repeated start, one byte read, then a nack ends it
	task automatic sread(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
		logic k;
		logic r;
		sstart();
		sbyte({a, 1'b0}, k);
		sbyte(p, k);
		sstart();
		sbyte({a, 1'b1}, k);
		for (int i = 7; i >= 0; i--) begin
			sbit(1'b1, r);
			d[i] = r;
		end
		sbit(1'b1, r);
		sstop();
	endtask : sread
endmodule : tcm_odu_model

/* sim/tcm_top_tb_top.sv */
// self-checking bench for tcm_top with the controller model
// assumes a short trim repeat count; the address strap starts high
`timescale 1ns/1ps

module tcm_top_tb_top import tcm_pkg::*; ;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] ctl_p, ctl_m, s, u;
	logic trim_n, scl, sda_m, sda_in, sda_oe_n, sda_out, irq, rf_tx, ant2, pa_a, det_oe_n;
	logic if_tx, pa_b, rx_a, rx_b, pot_up, shut, alert_out, alert_oe_n, alert_line;
	logic strap = 1'b1;
	logic [5:0] pot_pos;
	logic [7:0] sd;
	logic [7:0] temp_code = 8'h00, reg_wdata = 8'h00, rdata;
	logic temp_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, hot;
	logic [2:0] reg_addr = 3'h0, acks;
	logic [7:0] expq[$];
	logic [7:0] codes [6] = '{8'h7d, 8'hff, 8'hc9, 8'hc8, 8'h7f, 8'h00};
	int err_count = 0, n_tests = 0, seed = 32'h8d76;
	always #5 clk = ~clk;
	assign sda_in = sda_m & (sda_oe_n | sda_out);
	// shared alert line with its pull-up
	assign alert_line = alert_oe_n | alert_out;
	tcm_odu_model u_odu (.clk(clk), .sda_wire(sda_in), .ctl_p(ctl_p), .ctl_m(ctl_m),
		.trim_n(trim_n), .scl(scl), .sda_m(sda_m));
	tcm_top #(.REPEAT_CYC(50)) u_dut (.CLK(clk), .RESET_N(reset_n), .CTL_P(ctl_p),
		.CTL_M(ctl_m), .TRIM_N(trim_n), .SCL(scl), .SDA_IN(sda_in), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .ADDR_STRAP(strap), .TEMP_CODE(temp_code), .TEMP_VALID(temp_valid),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(rdata), .RF_SWITCH_TX(rf_tx), .IF_SWITCH_TX(if_tx), .ANT_PORT2(ant2),
		.PA_A_ON(pa_a), .PA_B_ON(pa_b), .RX_A_ON(rx_a), .RX_B_ON(rx_b), .POT_POSITION(pot_pos),
		.POT_UP(pot_up), .DET_OE_N(det_oe_n), .SHUTDOWN(shut), .ALERT_OUT(alert_out),
		.ALERT_OE_N(alert_oe_n), .IRQ(irq));
	// ****
	// drivers and the read-data watcher
	// ****
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		expq.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic temp(input logic [7:0] c);
		@(posedge clk);
		temp_code <= c;
		temp_valid <= 1'b1;
		@(posedge clk);
		temp_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : temp
	task automatic chk(input logic v, input logic e);
		n_tests++;
		if (v !== e) begin
			err_count++;
			$display("[FAIL] %0t pin %b", $time, v);
		end
	endtask : chk
	function automatic logic [7:0] pot_after(input int n);
		logic [5:0] p;
		logic up;
		p = POT_RESET;
		up = 1'b1;
		repeat (n) begin
			p = up ? p + 6'h01 : p - 6'h01;
			if (p == POT_MAX) up = 1'b0;
			if (p == POT_MIN) up = 1'b1;
		end
		return {1'b0, up, p};
	endfunction : pot_after
	always @(posedge clk) rd_q <= reg_rd;
	always @(negedge clk) begin
		if (rd_q) begin
			n_tests++;
			if (expq.size() == 0 || rdata !== expq[0]) begin
				err_count++;
				$display("[FAIL] %0t read data %h", $time, rdata);
			end
			if (expq.size() != 0) void'(expq.pop_front());
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// the run needs about 14k cycles; far beyond that is a hang
	initial begin
		#400_000;
		err_count++;
		stop_test();
	end
	// ****
	// tests
	// ****
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(RA_STATUS, STATUS_RESET);
		rd(RA_MASK, MASK_RESET);
		rd(RA_CONTROL, 8'h3f);
		rd(RA_POT, 8'h60);
		rd(RA_TEMP, 8'h00);
		rd(RA_CRIT, 8'h7f);
		rd(RA_LOW, 8'hc9);
		rd(3'h7, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			s = 6'($random(seed));
			u = 6'($random(seed) & $random(seed));
			u_odu.set_lanes(s, u);
			repeat (4) @(negedge clk);
			chk(rf_tx, s[0] | u[0]);
			chk(ant2, s[1] | u[1]);
			chk(pa_a, !(s[2] | u[2]));
			chk(det_oe_n, s[2] | u[2]);
			chk(if_tx, s[0] | u[0]);
			chk(pa_b, !(s[3] | u[3]));
			chk(rx_a, !(s[4] | u[4]));
			chk(rx_b, !(s[5] | u[5]));
			rd(RA_CONTROL, {2'b00, s | u});
		end
		$display("test lanes done");
		foreach (codes[i]) begin
			temp(codes[i]);
			hot = $signed(codes[i]) >= $signed(CRIT_RESET) || $signed(codes[i]) < $signed(LOW_RESET);
			@(negedge clk);
			chk(shut, hot);
			chk(alert_line, !hot);
			rd(RA_TEMP, codes[i]);
			rd(RA_CONTROL, {1'b0, hot, s | u});
		end
		rd(RA_STATUS, 8'h03);
		wr(RA_MASK, 8'h01);
		repeat (3) @(negedge clk);
		chk(irq, 1'b1);
		wr(RA_STATUS, 8'h01);
		repeat (3) @(negedge clk);
		chk(irq, 1'b0);
		rd(RA_STATUS, 8'h02);
		wr(RA_MASK, 8'h00);
		wr(RA_STATUS, 8'h0f);
		$display("test thermal done");
		u_odu.trim(1'b0);
		repeat (100) @(posedge clk);
		u_odu.trim(1'b1);
		repeat (2200) @(posedge clk);
		rd(RA_POT, 8'h60);
		u_odu.trim(1'b0);
		repeat (4477) @(posedge clk);
		rd(RA_POT, pot_after(50));
		@(negedge clk);
		chk({1'b0, pot_up, pot_pos} == pot_after(50), 1'b1);
		repeat (2248) @(posedge clk);
		rd(RA_POT, pot_after(95));
		rd(RA_STATUS, 8'h04);
		u_odu.trim(1'b1);
		repeat (2500) @(posedge clk);
		wr(RA_STATUS, 8'h0f);
		$display("test trim done");
		u_odu.swrite(SER_ADDR_DEFAULT, SP_CRIT, 8'h40, acks);
		chk(acks[2], 1'b0);
		u_odu.swrite({SER_ADDR_DEFAULT[6:1], 1'b1}, SP_CRIT, 8'h40, acks);
		chk(&acks, 1'b1);
		rd(RA_CRIT, 8'h40);
		rd(RA_STATUS, 8'h08);
		u_odu.sread({SER_ADDR_DEFAULT[6:1], 1'b1}, SP_CRIT, sd);
		chk(sd == 8'h40, 1'b1);
		temp(8'h45);
		rd(RA_CONTROL, {2'b01, s | u});
		u_odu.sread({SER_ADDR_DEFAULT[6:1], 1'b1}, SP_FLAGS, sd);
		chk(sd == 8'h01, 1'b1);
		u_odu.sread({SER_ADDR_DEFAULT[6:1], 1'b1}, SP_TEMP, sd);
		chk(sd == 8'h45, 1'b1);
		strap <= 1'b0;
		u_odu.swrite(SER_ADDR_DEFAULT, SP_LOW, 8'h80, acks);
		chk(&acks, 1'b1);
		rd(RA_LOW, 8'h80);
		$display("test serial done");
		repeat (4) @(posedge clk);
		stop_test();
	end
endmodule : tcm_top_tb_top
